// file: core/legacy_keyboard_emulation_regs.v
`timescale 1ns/1ps
`default_nettype none

`include "legacy_kbd_emu_defines.vh"

module legacy_keyboard_emulation_regs (
	input wire i_mclk,
	input wire i_rst,
	// Emulation control inputs
	input wire i_legacy_emulation_enable,
	input wire i_gate_a20_seq,
	// Memory cycles in the operational space
	input wire i_mem_wr,
	input wire i_mem_rd,
	input wire [`EMU_ADDR_W-1:0] i_mem_addr,
	input wire [31:0] i_mem_wdata,
	output wire [31:0] o_mem_rdata,
	output wire o_mem_rvalid,
	output wire o_mem_hit,
	// Legacy I/O cycles
	input wire i_io_rd,
	input wire i_io_wr,
	input wire [`EMU_IO_ADDR_W-1:0] i_io_addr,
	input wire [`EMU_BYTE_W-1:0] i_io_wdata,
	output wire o_io_claim,
	output wire [`EMU_BYTE_W-1:0] o_io_rdata,
	output wire o_io_rvalid,
	// State seen by the rest of the controller
	output wire [`EMU_BYTE_W-1:0] o_captured_input,
	output wire [`EMU_BYTE_W-1:0] o_returned_output,
	output wire [`EMU_BYTE_W-1:0] o_status_word,
	output wire o_emulation_irq_cond
);

	// ==========================================================
	// Declarations

	// Port strobes from the decoder
	wire rd_data_port;
	wire wr_data_port;
	wire rd_cmd_port;
	wire wr_cmd_port;
	wire io_write;
	wire io_read;

	// Register selects in the operational space
	wire sel_input;
	wire sel_output;
	wire sel_status;
	wire sel_any;

	// Memory write enables
	wire we_input;
	wire we_output;
	wire we_status;

	// Byte views
	wire [`EMU_BYTE_W-1:0] mem_byte;
	wire [`EMU_BYTE_W-1:0] captured_input;
	wire [`EMU_BYTE_W-1:0] returned_output;

	// Status flag events
	wire out_full_clear;
	wire in_full_set;
	wire cmd_data_clear;
	wire cmd_data_set;

	// Per-bit status terms
	wire [`EMU_BYTE_W-1:0] flag_set;
	wire [`EMU_BYTE_W-1:0] flag_clr_port;
	wire [`EMU_BYTE_W-1:0] flag_clr_read;
	genvar g;

	// Flag view
	wire in_full;

	// Status storage
	reg [`EMU_BYTE_W-1:0] status_reg;
	wire [`EMU_BYTE_W-1:0] status_next;

	// Memory read answer
	reg [31:0] mem_rdata_reg;
	reg [31:0] mem_rdata_next;
	reg mem_rvalid_reg;
	reg mem_rvalid_next;
	reg mem_hit_reg;
	reg mem_hit_next;

	// Port read answer
	reg [`EMU_BYTE_W-1:0] io_rdata_reg;
	reg [`EMU_BYTE_W-1:0] io_rdata_next;
	reg io_rvalid_reg;
	reg io_rvalid_next;

	// ==========================================================
	// Legacy port decode

	// Port strobes exist only while emulation is enabled
	legacy_port_decode u_port_decode (
		.i_enable(i_legacy_emulation_enable),
		.i_io_addr(i_io_addr),
		.i_io_rd(i_io_rd),
		.i_io_wr(i_io_wr),
		.o_rd_data_port(rd_data_port),
		.o_wr_data_port(wr_data_port),
		.o_rd_cmd_port(rd_cmd_port),
		.o_wr_cmd_port(wr_cmd_port),
		.o_claim(o_io_claim)
	);

	// Any decoded port write, data or command
	assign io_write = wr_data_port || wr_cmd_port;

	// Any decoded port read, data or command
	assign io_read = rd_data_port || rd_cmd_port;

	// ==========================================================
	// Memory address decode

	// One aligned word per register
	assign sel_input = (i_mem_addr == `EMU_CAPTURED_INPUT_OFS);
	assign sel_output = (i_mem_addr == `EMU_RETURNED_OUTPUT_OFS);
	assign sel_status = (i_mem_addr == `EMU_STATUS_WORD_OFS);
	assign sel_any = sel_input || sel_output || sel_status;

	// Write enables
	assign we_input = i_mem_wr && sel_input;
	assign we_output = i_mem_wr && sel_output;
	assign we_status = i_mem_wr && sel_status;

	// Low byte only; upper word bits are dropped, reserved as zero
	assign mem_byte = i_mem_wdata[`EMU_BYTE_W-1:0];

	// ==========================================================
	// Captured-input register

	// Every decoded port write stores its byte here
	emu_byte_reg u_captured_input (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_mem_we(we_input),
		.i_mem_data(mem_byte),
		.i_evt_we(io_write),
		.i_evt_data(i_io_wdata),
		.o_value(captured_input)
	);

	// ==========================================================
	// Returned-output register

	// Only software fills this byte; port reads leave it alone
	emu_byte_reg u_returned_output (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_mem_we(we_output),
		.i_mem_data(mem_byte),
		.i_evt_we(1'b0),
		.i_evt_data(`EMU_BYTE_RESET),
		.o_value(returned_output)
	);

	// ==========================================================
	// Status word

	// Flag events from claimed port cycles; a command port read raises none
	assign out_full_clear = rd_data_port;
	assign in_full_set = io_write && !i_gate_a20_seq;
	assign cmd_data_clear = wr_data_port;
	assign cmd_data_set = wr_cmd_port;

	// Per-bit next value. Port write sets and clears beat a memory write, so
	// a port write event is never lost; a memory write that sets output-full
	// beats the clear of a same-cycle data port read.
	generate
		for (g = 0; g < `EMU_BYTE_W; g = g + 1) begin : g_status_bit
			// Steer each event onto the bit it belongs to
			assign flag_set[g] = ((g == `EMU_IN_FULL_BIT) && in_full_set)
				|| ((g == `EMU_CMD_DATA_BIT) && cmd_data_set);
			assign flag_clr_port[g] = (g == `EMU_CMD_DATA_BIT) && cmd_data_clear;
			assign flag_clr_read[g] = (g == `EMU_OUT_FULL_BIT) && out_full_clear;

			// Priority chain for this bit
			assign status_next[g] = flag_set[g] ? 1'b1
				: flag_clr_port[g] ? 1'b0
				: we_status ? mem_byte[g]
				: flag_clr_read[g] ? 1'b0
				: status_reg[g];
		end
	endgenerate

	// Status storage
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			status_reg <= `EMU_STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// ==========================================================
	// Memory read path

	// Read data; unmapped offsets return zero
	always @* begin
		mem_rdata_next = `EMU_RDATA_ZERO;
		if (sel_input) begin
			mem_rdata_next = {`EMU_UPPER_ZERO, captured_input};
		end else if (sel_output) begin
			mem_rdata_next = {`EMU_UPPER_ZERO, returned_output};
		end else if (sel_status) begin
			mem_rdata_next = {`EMU_UPPER_ZERO, status_reg};
		end
	end

	// Answer strobe follows the request; the hit flag holds until the next read
	always @* begin
		mem_rvalid_next = i_mem_rd;
		mem_hit_next = mem_hit_reg;
		if (i_mem_rd) begin
			mem_hit_next = sel_any;
		end
	end

	// Read answer one cycle after the request, held until the next one
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mem_rdata_reg <= `EMU_RDATA_ZERO;
			mem_rvalid_reg <= 1'b0;
			mem_hit_reg <= 1'b0;
		end else begin
			mem_rvalid_reg <= mem_rvalid_next;
			mem_hit_reg <= mem_hit_next;
			if (i_mem_rd) begin
				mem_rdata_reg <= mem_rdata_next;
			end
		end
	end

	// Outputs straight from the answer flops
	assign o_mem_rdata = mem_rdata_reg;
	assign o_mem_rvalid = mem_rvalid_reg;
	assign o_mem_hit = mem_hit_reg;

	// ==========================================================
	// Legacy port read path

	// Data port returns the software byte, command port the status
	always @* begin
		io_rdata_next = io_rdata_reg;
		io_rvalid_next = io_read;
		if (rd_data_port) begin
			io_rdata_next = returned_output;
		end else if (rd_cmd_port) begin
			io_rdata_next = status_reg;
		end
	end

	// Port read answer one cycle after a claimed read
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			io_rdata_reg <= `EMU_BYTE_RESET;
			io_rvalid_reg <= 1'b0;
		end else begin
			io_rdata_reg <= io_rdata_next;
			io_rvalid_reg <= io_rvalid_next;
		end
	end

	// Port answer straight from its flops
	assign o_io_rdata = io_rdata_reg;
	assign o_io_rvalid = io_rvalid_reg;

	// ==========================================================
	// State outputs

	// Register contents for the rest of the controller
	assign o_captured_input = captured_input;
	assign o_returned_output = returned_output;
	assign o_status_word = status_reg;

	// Flag view for the interrupt condition
	assign in_full = status_reg[`EMU_IN_FULL_BIT];

	// Pending input byte with emulation on asks for the handler
	assign o_emulation_irq_cond = in_full && i_legacy_emulation_enable;

endmodule // legacy_keyboard_emulation_regs

`default_nettype wire

// file: core/legacy_kbd_emu_defines.vh
`ifndef LEGACY_KBD_EMU_DEFINES_VH
`define LEGACY_KBD_EMU_DEFINES_VH

// ==========================================================
// Operational space offsets (byte addresses)
`define EMU_ADDR_W 12
`define EMU_CAPTURED_INPUT_OFS 12'h104
`define EMU_RETURNED_OUTPUT_OFS 12'h108
`define EMU_STATUS_WORD_OFS 12'h10c

// ==========================================================
// Legacy I/O ports
`define EMU_IO_ADDR_W 8
`define EMU_PORT_DATA 8'h60
`define EMU_PORT_CMD 8'h64

// ==========================================================
// Field layout and reset values
`define EMU_BYTE_W 8
`define EMU_BYTE_RESET 8'h00
`define EMU_STATUS_RESET 8'h00
`define EMU_OUT_FULL_BIT 0
`define EMU_IN_FULL_BIT 1
`define EMU_CMD_DATA_BIT 3
`define EMU_UPPER_ZERO 24'h000000
`define EMU_RDATA_ZERO 32'h00000000

`endif

// file: core/emu_byte_reg.v
`timescale 1ns/1ps
`default_nettype none

`include "legacy_kbd_emu_defines.vh"

// ==========================================================
// Byte register written by software over memory cycles and by
// legacy port events; the port event wins when both land together.
module emu_byte_reg (
	input wire i_mclk,
	input wire i_rst,
	input wire i_mem_we,
	input wire [`EMU_BYTE_W-1:0] i_mem_data,
	input wire i_evt_we,
	input wire [`EMU_BYTE_W-1:0] i_evt_data,
	output wire [`EMU_BYTE_W-1:0] o_value
);

	reg [`EMU_BYTE_W-1:0] value_reg;
	reg [`EMU_BYTE_W-1:0] value_next;

	// Next value: port event over memory write over hold
	always @* begin
		value_next = value_reg;
		if (i_mem_we) begin
			value_next = i_mem_data;
		end
		if (i_evt_we) begin
			value_next = i_evt_data;
		end
	end

	// Storage
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			value_reg <= `EMU_BYTE_RESET;
		end else begin
			value_reg <= value_next;
		end
	end

	assign o_value = value_reg;

endmodule // emu_byte_reg

`default_nettype wire

// file: core/legacy_port_decode.v
`timescale 1ns/1ps
`default_nettype none

`include "legacy_kbd_emu_defines.vh"

// ==========================================================
// Decodes I/O cycles to the two legacy keyboard ports
module legacy_port_decode (
	input wire i_enable,
	input wire [`EMU_IO_ADDR_W-1:0] i_io_addr,
	input wire i_io_rd,
	input wire i_io_wr,
	output wire o_rd_data_port,
	output wire o_wr_data_port,
	output wire o_rd_cmd_port,
	output wire o_wr_cmd_port,
	output wire o_claim
);

	wire hit_data;
	wire hit_cmd;

	// Address match, gated by the emulation enable
	assign hit_data = i_enable && (i_io_addr == `EMU_PORT_DATA);
	assign hit_cmd = i_enable && (i_io_addr == `EMU_PORT_CMD);

	// Strobes per port and direction
	assign o_rd_data_port = hit_data && i_io_rd;
	assign o_wr_data_port = hit_data && i_io_wr;
	assign o_rd_cmd_port = hit_cmd && i_io_rd;
	assign o_wr_cmd_port = hit_cmd && i_io_wr;

	// Claim only cycles that were decoded
	assign o_claim = (hit_data || hit_cmd) && (i_io_rd || i_io_wr);

endmodule // legacy_port_decode

`default_nettype wire

// file: verification/legacy_kbd_emu_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "legacy_kbd_emu_defines.vh"
// ==========================================================
// Port-level checks of the emulation register bank
module legacy_kbd_emu_props (
	input wire i_mclk,
	input wire i_rst,
	input wire i_legacy_emulation_enable,
	input wire i_gate_a20_seq,
	input wire i_mem_wr,
	input wire i_mem_rd,
	input wire [`EMU_ADDR_W-1:0] i_mem_addr,
	input wire [31:0] i_mem_wdata,
	input wire [31:0] o_mem_rdata,
	input wire o_mem_rvalid,
	input wire o_mem_hit,
	input wire i_io_rd,
	input wire i_io_wr,
	input wire [`EMU_IO_ADDR_W-1:0] i_io_addr,
	input wire [`EMU_BYTE_W-1:0] i_io_wdata,
	input wire o_io_claim,
	input wire [`EMU_BYTE_W-1:0] o_io_rdata,
	input wire o_io_rvalid,
	input wire [`EMU_BYTE_W-1:0] o_captured_input,
	input wire [`EMU_BYTE_W-1:0] o_returned_output,
	input wire [`EMU_BYTE_W-1:0] o_status_word,
	input wire o_emulation_irq_cond
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Decoded port cycles and a memory write of the status word
	wire port_hit = (i_io_addr == `EMU_PORT_DATA) || (i_io_addr == `EMU_PORT_CMD);
	wire stat_wr = i_mem_wr && (i_mem_addr == `EMU_STATUS_WORD_OFS);
	wire rd_data = o_io_claim && i_io_rd && !i_io_wr && (i_io_addr == `EMU_PORT_DATA);
	wire rd_cmd = o_io_claim && i_io_rd && !i_io_wr && (i_io_addr == `EMU_PORT_CMD);
	wire wr_any = o_io_claim && i_io_wr;
	a_claim_decode: assert property (o_io_claim == (i_legacy_emulation_enable && port_hit && (i_io_rd || i_io_wr)))
		else $error("port claim does not match decode");
	a_port_capture: assert property (wr_any |=> o_captured_input == $past(i_io_wdata))
		else $error("port write byte not captured");
	a_data_read: assert property (rd_data |=> o_io_rvalid && o_io_rdata == $past(o_returned_output))
		else $error("data port read returned wrong byte");
	a_out_full_clear: assert property (rd_data && !(stat_wr && i_mem_wdata[0]) |=> !o_status_word[0])
		else $error("output full not cleared by data port read");
	a_status_read: assert property (rd_cmd && !stat_wr |=> o_io_rdata == $past(o_status_word) && $stable(o_status_word))
		else $error("status port read wrong or changed status");
	a_cmd_flag: assert property (wr_any |=> o_status_word[3] == ($past(i_io_addr) == `EMU_PORT_CMD))
		else $error("command flag wrong after port write");
	a_in_full_set: assert property (wr_any && !i_gate_a20_seq |=> o_status_word[1])
		else $error("input full not set by port write");
	a_disabled_hold: assert property (!i_legacy_emulation_enable && !i_mem_wr |=> $stable(o_captured_input) && $stable(o_returned_output) && $stable(o_status_word))
		else $error("registers changed while emulation off");
	a_irq_cond: assert property (o_emulation_irq_cond == (o_status_word[1] && i_legacy_emulation_enable))
		else $error("interrupt condition mismatch");
	a_mem_read_word: assert property (i_mem_rd |=> o_mem_rvalid && o_mem_rdata[31:8] == 24'h000000)
		else $error("memory read answer missing or upper bits set");
endmodule // legacy_kbd_emu_props
bind legacy_keyboard_emulation_regs legacy_kbd_emu_props i_props (.*);
`default_nettype wire

// file: verification/io_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host processor issuing single-byte legacy port cycles
module io_host_model (
	input wire logic i_mclk,
	input wire logic i_io_claim,
	input wire logic [7:0] i_io_rdata,
	input wire logic i_io_rvalid,
	output var logic o_io_rd,
	output var logic o_io_wr,
	output var logic [7:0] o_io_addr,
	output var logic [7:0] o_io_wdata
);
	// Idle bus at start
	initial begin
		o_io_rd = 1'b0;
		o_io_wr = 1'b0;
		o_io_addr = 8'h00;
		o_io_wdata = 8'h00;
	end
	// One strobe cycle, then both strobes drop and address and data show the inverse of the last value
	task automatic io_cycle(input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
		output logic claim, output logic [7:0] rdata, output logic rvalid);
		@(posedge i_mclk);
		#1;
		o_io_rd = rd;
		o_io_wr = !rd;
		o_io_addr = addr;
		o_io_wdata = wdata;
		#1;
		claim = i_io_claim;
		@(posedge i_mclk);
		#1;
		o_io_rd = 1'b0;
		o_io_wr = 1'b0;
		o_io_addr = ~addr;
		o_io_wdata = ~wdata;
		rdata = i_io_rdata;
		rvalid = i_io_rvalid;
	endtask
endmodule // io_host_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the emulation register bank
module tb;
	logic i_mclk, i_rst, en, a20, mem_wr, mem_rd, io_rd, io_wr, claim, io_rv, rv, hit, irq;
	logic [11:0] mem_addr;
	logic [31:0] mem_wdata, rdata;
	logic [7:0] io_addr, io_wdata, io_rdata, cap, ret, stat;
	int n_errors, comparisons, cycles;
	legacy_keyboard_emulation_regs i_dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_legacy_emulation_enable(en), .i_gate_a20_seq(a20), .i_mem_wr(mem_wr),
		.i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .o_mem_rdata(rdata),
		.o_mem_rvalid(rv), .o_mem_hit(hit), .i_io_rd(io_rd), .i_io_wr(io_wr),
		.i_io_addr(io_addr), .i_io_wdata(io_wdata), .o_io_claim(claim), .o_io_rdata(io_rdata),
		.o_io_rvalid(io_rv), .o_captured_input(cap), .o_returned_output(ret),
		.o_status_word(stat), .o_emulation_irq_cond(irq));
	io_host_model i_host (.i_mclk(i_mclk), .i_io_claim(claim), .i_io_rdata(io_rdata),
		.i_io_rvalid(io_rv), .o_io_rd(io_rd), .o_io_wr(io_wr), .o_io_addr(io_addr),
		.o_io_wdata(io_wdata));
	// Clock and hang guard
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			$display("[FAIL] %0t run timed out", $time);
			complete_run();
		end
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Memory cycles: strobe one clock, answer sampled the cycle after
	task automatic mem_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		#1;
		mem_wr = 1'b1;
		mem_addr = a;
		mem_wdata = d;
		@(posedge i_mclk);
		#1;
		mem_wr = 1'b0;
		mem_wdata = ~d;
	endtask
	task automatic mem_read(input logic [11:0] a, input logic [31:0] exp, input logic exp_hit);
		@(posedge i_mclk);
		#1;
		mem_rd = 1'b1;
		mem_addr = a;
		@(posedge i_mclk);
		#1;
		mem_rd = 1'b0;
		chk(rv, 1, "read valid");
		chk(rdata, exp, "read data");
		chk(hit, exp_hit, "read hit");
	endtask
	// Port cycle through the host model; for reads d is the expected byte
	task automatic io(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic ce);
		logic c, v;
		logic [7:0] r;
		i_host.io_cycle(rd, a, d, c, r, v);
		chk(c, ce, "port claim");
		if (rd) chk(v, ce, "port read valid");
		if (rd && ce) chk(r, d, "port read data");
	endtask
	// Test sequence
	initial begin
		i_rst = 1'b1;
		{en, a20, mem_wr, mem_rd, mem_addr, mem_wdata} = '0;
		en = 1'b1;
		repeat (4) @(posedge i_mclk);
		#1;
		i_rst = 1'b0;
		mem_read(12'h104, 32'h0, 1'b1);
		mem_read(12'h108, 32'h0, 1'b1);
		mem_read(12'h10c, 32'h0, 1'b1);
		mem_read(12'h100, 32'h0, 1'b0);
		$display("test reset values done");
		mem_write(12'h108, 32'ha5);
		chk(ret, 8'ha5, "returned byte");
		mem_write(12'h10c, 32'h01);
		io(1'b1, 8'h60, 8'ha5, 1'b1);
		mem_read(12'h10c, 32'h0, 1'b1);
		$display("test data port read done");
		io(1'b0, 8'h60, 8'h3c, 1'b1);
		chk(cap, 8'h3c, "captured byte");
		mem_read(12'h10c, 32'h02, 1'b1);
		chk(irq, 1, "interrupt condition");
		io(1'b0, 8'h64, 8'hd1, 1'b1);
		mem_read(12'h10c, 32'h0a, 1'b1);
		io(1'b1, 8'h64, 8'h0a, 1'b1);
		chk(stat, 8'h0a, "status after command read");
		mem_read(12'h10c, 32'h0a, 1'b1);
		mem_write(12'h104, 32'h5a);
		mem_read(12'h10c, 32'h0a, 1'b1);
		mem_read(12'h104, 32'h5a, 1'b1);
		$display("test port writes done");
		mem_write(12'h10c, 32'h0);
		a20 = 1'b1;
		io(1'b0, 8'h60, 8'h11, 1'b1);
		mem_read(12'h10c, 32'h0, 1'b1);
		a20 = 1'b0;
		$display("test gate sequence done");
		mem_write(12'h10c, 32'h02);
		en = 1'b0;
		io(1'b0, 8'h60, 8'h77, 1'b0);
		io(1'b0, 8'h64, 8'h88, 1'b0);
		io(1'b1, 8'h60, 8'h00, 1'b0);
		mem_read(12'h104, 32'h11, 1'b1);
		mem_read(12'h10c, 32'h02, 1'b1);
		chk(irq, 0, "interrupt condition off");
		$display("test emulation off done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
